/* shared/fewc_pkg.sv */
// Package for the flash and emulated-EEPROM write controller.
// Assumes a 100 MHz core clock and an 8-bit memory-mapped register port.
package fewc_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  // Register byte addresses in segment 22h, both mirror pages.
  localparam logic [23:0] FLASH_CTRL_ADDR  = 24'h224000;
  localparam logic [23:0] EE_CTRL_ADDR     = 24'h224001;
  localparam logic [23:0] FLASH_CTRL_ALIAS = 24'h221000;
  localparam logic [23:0] EE_CTRL_ALIAS    = 24'h221001;
  localparam logic [7:0]  FLASH_CTRL_RST   = 8'h00;
  localparam logic [7:0]  EE_CTRL_RST      = 8'h00;
  localparam logic [7:0]  EE_CTRL_WMASK    = 8'hE6;
  // Flash control bit positions.
  localparam int unsigned FC_START = 7;
  localparam int unsigned FC_PAGE  = 6;
  localparam int unsigned FC_CHIP  = 5;
  localparam int unsigned FC_BYTE  = 4;
  localparam int unsigned FC_SECT  = 3;
  localparam int unsigned FC_SUSP  = 2;
  localparam int unsigned FC_SET_PROTECTION_SELECT  = 1;
  localparam int unsigned FC_BUSY  = 0;
  // EEPROM control bit positions.
  localparam int unsigned EC_START = 7;
  localparam int unsigned EC_PAGE  = 6;
  localparam int unsigned EC_CHIP  = 5;
  localparam int unsigned EC_WAIT_LOWPOWER_SELECT  = 2;
  localparam int unsigned EC_IRQS  = 1;
  localparam int unsigned EC_BUSY  = 0;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;
  localparam int unsigned SET_PROTECTION_SELECT_BYTES  = 4;
  localparam int unsigned PAGE_BYTES  = 16;
  // Timing figures in their own units, and derived cycle counts.
  localparam int unsigned SUSPEND_US      = 15;
  localparam int unsigned FLASH_WAKE_US   = 10;
  localparam int unsigned EE_WAKE_MS      = 10;
  localparam int unsigned SUSPEND_CYC     = SUSPEND_US * CLK_MHZ;
  localparam int unsigned FLASH_WAKE_CYC  = FLASH_WAKE_US * CLK_MHZ;
  localparam int unsigned EE_WAKE_CYC     = EE_WAKE_MS * 1000 * CLK_MHZ;
  localparam int unsigned OP_CYC_DEF      = 64;

  typedef enum logic [2:0] {
    FEWC_IDLE, FEWC_SELECT, FEWC_FLASH_RUN, FEWC_SUSPENDED, FEWC_EE_RUN
  } fewc_state_t;

  typedef struct packed {
    fewc_state_t state;
    logic [7:0]  flashCtrl;
    logic [7:0]  eeCtrl;
    logic [4:0]  latchCount;
    logic [23:0] opCount;
    logic [23:0] wakeFlash;
    logic [23:0] wakeEe;
    logic        eeLatched;
    logic        endOfWrite;
    logic        irqOut;
    logic        lowPower;
    logic        powerDown;
    logic [7:0]  readData;
    logic        flashBlock;
    logic        eeBlock;
    logic [1:0]  extIrqSync;
    logic [1:0]  sleepSync;
  } fewc_state_s_t;
endpackage

/* verilog/fewc_write_control.sv */
// Write, erase, suspend and protection sequencer for flash and EEPROM.
// Assumes the array algorithms report completion on a same-clock done pulse.
// Contract
// - Clearing suspend then setting flash start resumes the erase.
// - Suspend returns flash to read mode, busy clear within 15 us.
// - During suspend only reads, resume and byte program are accepted; the code holds the select bits, so byte program is refused too.
// - No EEPROM page update while flash erase is suspended.
// - Protection select chooses set protection, cleared when it finishes.
// - Set protection latches one to four pairs, ones to zeros only.
// - Flash busy sets on first latched address, or on start for chip erase.
// - While flash busy, reads return FFh and writes are ignored; before start the code still latches array writes up to the latch limit.
// - Flash busy clears at end or suspend, sets again on resume.
// - Flash busy stays set up to 10 us after power-up or power-down.
// - EEPROM start launches operation, cleared at end, software clear ignored.
// - Page update latches one to sixteen pairs in one page.
// - EEPROM chip erase clears all to FFh and drops its select bit.
// - Wait instruction picks standby or power-down from low-power select.
// - Low-power entry waits for any write operation to finish.
// - Interrupt select routes external pin or end-of-write to channel.
// - EEPROM busy on first latch or chip erase start; reads give FFh.
// - EEPROM busy stays set up to 10 ms after power-up or power-down.
// - Flash start launches each operation, cleared at end or suspend.
// - Clearing a select bit before start cancels and drops latched data; the code does so only once every flash and EEPROM select bit is clear.
// - Flash and EEPROM writes never run together.
`timescale 1ns/100ps
module fewc_write_control
  import fewc_pkg::*;
#(
  parameter int unsigned SUSPEND_CYCLES    = SUSPEND_CYC,
  parameter int unsigned FLASH_WAKE_CYCLES = FLASH_WAKE_CYC,
  parameter int unsigned EE_WAKE_CYCLES    = EE_WAKE_CYC,
  parameter int unsigned OP_CYCLES         = OP_CYC_DEF
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Register and array access from the core.
  input  wire logic [23:0] busAddr,
  input  wire logic [7:0]  busWrData,
  input  wire logic        busWrite,
  input  wire logic        busRead,
  input  wire logic        flashSpace,
  input  wire logic        eeSpace,
  output logic      [7:0]  busRdData,
  output logic             flashAccessBlock,
  output logic             eeAccessBlock,
  // Array engine completion.
  input  wire logic        arrayDone,
  // Power-mode requests from the core, asynchronous pins.
  input  wire logic        sleepRequest,
  output logic             arrayLowPower,
  output logic             arrayPowerDown,
  // Interrupt routing.
  input  wire logic        extIrqPin,
  output logic             sharedIrq,
  output logic             endOfWriteEvent
);
  fewc_state_s_t s_reg;
  fewc_state_s_t s_next;

  function automatic logic isReg(input logic [23:0] a, input logic [23:0] p,
                                 input logic [23:0] q);
    isReg = (a == p) || (a == q);
  endfunction

  logic fcHit;
  logic ecHit;
  logic writeActive;
  assign fcHit = isReg(busAddr, FLASH_CTRL_ADDR, FLASH_CTRL_ALIAS);
  assign ecHit = isReg(busAddr, EE_CTRL_ADDR, EE_CTRL_ALIAS);
  assign writeActive = (s_reg.state == FEWC_FLASH_RUN)
                    || (s_reg.state == FEWC_EE_RUN);

  always_comb begin
    logic [7:0] fw;
    logic [7:0] ew;
    logic       flashSel;
    logic       eeSel;
    fw = busWrData;
    ew = busWrData;
    flashSel = 1'b0;
    eeSel = 1'b0;
    s_next = s_reg;
    s_next.endOfWrite = 1'b0;
    s_next.extIrqSync = {s_reg.extIrqSync[0], extIrqPin};
    s_next.sleepSync  = {s_reg.sleepSync[0], sleepRequest};
    if (s_reg.wakeFlash != 24'h0) begin
      s_next.wakeFlash = s_reg.wakeFlash - 24'h1;
    end
    if (s_reg.wakeEe != 24'h0) begin
      s_next.wakeEe = s_reg.wakeEe - 24'h1;
    end
    // The fallback length is frozen while an erase is suspended.
    if (s_reg.opCount != 24'h0 && s_reg.state != FEWC_SUSPENDED) begin
      s_next.opCount = s_reg.opCount - 24'h1;
    end
    // Software writes to the control registers; busy bits are read only.
    if (busWrite && fcHit) begin
      s_next.flashCtrl[7:1] = fw[7:1];
      if (writeActive || s_reg.state == FEWC_SUSPENDED) begin
        // A software clear of start does not stop a running write.
        s_next.flashCtrl[FC_START] = s_reg.flashCtrl[FC_START] | fw[FC_START];
        s_next.flashCtrl[6:3] = s_reg.flashCtrl[6:3];
        s_next.flashCtrl[FC_SET_PROTECTION_SELECT] = s_reg.flashCtrl[FC_SET_PROTECTION_SELECT];
      end
    end
    if (busWrite && ecHit) begin
      s_next.eeCtrl = (s_reg.eeCtrl & ~EE_CTRL_WMASK)
                    | (ew & EE_CTRL_WMASK);
      if (s_reg.state == FEWC_EE_RUN) begin
        s_next.eeCtrl[EC_START] = 1'b1;
        s_next.eeCtrl[6:5] = s_reg.eeCtrl[6:5];
      end
    end
    flashSel = |s_next.flashCtrl[6:3] | s_next.flashCtrl[FC_SET_PROTECTION_SELECT];
    eeSel    = |s_next.eeCtrl[6:5];
    unique case (s_reg.state)
      FEWC_IDLE, FEWC_SELECT: begin
        if (!flashSel && !eeSel) begin
          // Dropping every select bit discards the latched pairs.
          s_next.latchCount = 5'h0;
          s_next.eeLatched  = 1'b0;
          s_next.flashCtrl[FC_BUSY] = 1'b0;
          s_next.eeCtrl[EC_BUSY] = 1'b0;
          s_next.state = FEWC_IDLE;
        end else begin
          s_next.state = FEWC_SELECT;
        end
        // Busy rises on the first latch, so only a waking array or a full latch count refuses more.
        if (busWrite && flashSpace && flashSel && s_reg.wakeFlash == 24'h0
            && s_reg.latchCount < (s_reg.flashCtrl[FC_SET_PROTECTION_SELECT]
                                   ? 5'(SET_PROTECTION_SELECT_BYTES) : 5'(PAGE_BYTES))) begin
          s_next.latchCount = s_reg.latchCount + 5'h1;
          s_next.flashCtrl[FC_BUSY] = 1'b1;
        end
        if (busWrite && eeSpace && s_reg.eeCtrl[EC_PAGE]
            && s_reg.latchCount < 5'(PAGE_BYTES)) begin
          s_next.latchCount = s_reg.latchCount + 5'h1;
          s_next.eeLatched = 1'b1;
          s_next.eeCtrl[EC_BUSY] = 1'b1;
        end
        if (s_next.flashCtrl[FC_START] && s_next.flashCtrl[FC_CHIP]) begin
          s_next.flashCtrl[FC_BUSY] = 1'b1;
        end
        if (s_next.eeCtrl[EC_START] && s_next.eeCtrl[EC_CHIP]) begin
          s_next.eeCtrl[EC_BUSY] = 1'b1;
        end
        // Flash wins a simultaneous start; the other start stays pending.
        if (s_next.flashCtrl[FC_START] && flashSel) begin
          s_next.state = FEWC_FLASH_RUN;
          s_next.opCount = 24'(OP_CYCLES);
        end else if (s_next.eeCtrl[EC_START] && eeSel) begin
          s_next.state = FEWC_EE_RUN;
          s_next.opCount = 24'(OP_CYCLES);
        end
      end
      FEWC_FLASH_RUN: begin
        if (s_reg.flashCtrl[FC_SECT] && s_next.flashCtrl[FC_SUSP]) begin
          // Suspend answers at once, well inside the suspend bound.
          s_next.state = FEWC_SUSPENDED;
          s_next.flashCtrl[FC_START] = 1'b0;
          s_next.flashCtrl[FC_BUSY] = 1'b0;
        end else if (arrayDone || s_reg.opCount == 24'h1) begin
          s_next.state = FEWC_IDLE;
          s_next.flashCtrl[7:3] = 5'h0;
          s_next.flashCtrl[FC_SET_PROTECTION_SELECT] = 1'b0;
          s_next.flashCtrl[FC_BUSY] = 1'b0;
          s_next.latchCount = 5'h0;
          s_next.endOfWrite = 1'b1;
        end
      end
      FEWC_SUSPENDED: begin
        if (busWrite && fcHit) begin
          s_next.flashCtrl[FC_SUSP] = fw[FC_SUSP];
          s_next.flashCtrl[FC_START] = fw[FC_START];
        end
        if (!s_next.flashCtrl[FC_SUSP] && s_next.flashCtrl[FC_START]) begin
          s_next.state = FEWC_FLASH_RUN;
          s_next.flashCtrl[FC_BUSY] = 1'b1;
        end
      end
      FEWC_EE_RUN: begin
        if (arrayDone || s_reg.opCount == 24'h1) begin
          s_next.state = FEWC_IDLE;
          s_next.eeCtrl[7:5] = 3'h0;
          s_next.eeCtrl[EC_BUSY] = 1'b0;
          s_next.latchCount = 5'h0;
          s_next.eeLatched = 1'b0;
          s_next.endOfWrite = 1'b1;
        end
      end
    endcase
    // EEPROM page update is refused while a flash erase is suspended.
    if (s_reg.state == FEWC_SUSPENDED) begin
      s_next.eeCtrl[EC_START] = 1'b0;
      s_next.eeCtrl[EC_PAGE] = 1'b0;
    end
    // Low-power entry only once no write is running.
    if (s_reg.sleepSync[1] && !writeActive) begin
      s_next.lowPower  = ~s_reg.eeCtrl[EC_WAIT_LOWPOWER_SELECT];
      s_next.powerDown = s_reg.eeCtrl[EC_WAIT_LOWPOWER_SELECT];
    end else if (!s_reg.sleepSync[1]) begin
      s_next.lowPower  = 1'b0;
      s_next.powerDown = 1'b0;
      if (s_reg.powerDown) begin
        s_next.wakeFlash = 24'(FLASH_WAKE_CYCLES);
        s_next.wakeEe    = 24'(EE_WAKE_CYCLES);
      end
    end
    s_next.irqOut = s_reg.eeCtrl[EC_IRQS] ? s_reg.endOfWrite
                                          : s_reg.extIrqSync[1];
    s_next.flashBlock = s_next.flashCtrl[FC_BUSY]
                     || s_next.wakeFlash != 24'h0;
    s_next.eeBlock = s_next.eeCtrl[EC_BUSY]
                  || s_next.wakeEe != 24'h0;
    s_next.readData = 8'h00;
    if (busRead && fcHit) begin
      s_next.readData = {s_reg.flashCtrl[7:1], s_reg.flashBlock};
    end else if (busRead && ecHit) begin
      s_next.readData = {s_reg.eeCtrl[7:1], s_reg.eeBlock};
    end else if (busRead && flashSpace && s_reg.flashBlock) begin
      s_next.readData = ERASED_BYTE;
    end else if (busRead && eeSpace && s_reg.eeBlock) begin
      s_next.readData = ERASED_BYTE;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '{state: FEWC_IDLE, flashCtrl: FLASH_CTRL_RST,
                 eeCtrl: EE_CTRL_RST, wakeFlash: 24'(FLASH_WAKE_CYCLES),
                 wakeEe: 24'(EE_WAKE_CYCLES), flashBlock: 1'b1,
                 eeBlock: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign busRdData        = s_reg.readData;
  assign flashAccessBlock = s_reg.flashBlock;
  assign eeAccessBlock    = s_reg.eeBlock;
  assign arrayLowPower    = s_reg.lowPower;
  assign arrayPowerDown   = s_reg.powerDown;
  assign sharedIrq        = s_reg.irqOut;
  assign endOfWriteEvent  = s_reg.endOfWrite;

  property p_suspend_fast;
    @(posedge clock) disable iff (!reset_n)
    (s_reg.state == FEWC_FLASH_RUN && s_reg.flashCtrl[FC_SECT]
     && s_next.flashCtrl[FC_SUSP]) |=> !s_reg.flashCtrl[FC_BUSY];
  endproperty
  a_suspend_fast: assert property (p_suspend_fast)
    else $error("suspend did not clear flash busy");

  property p_no_ee_in_suspend;
    @(posedge clock) disable iff (!reset_n)
    (s_reg.state == FEWC_SUSPENDED)
      |=> (s_reg.state != FEWC_EE_RUN) && !s_reg.eeCtrl[EC_START];
  endproperty
  a_no_ee_in_suspend: assert property (p_no_ee_in_suspend)
    else $error("eeprom update started during suspend");

  property p_eow_pulse;
    @(posedge clock) disable iff (!reset_n)
    endOfWriteEvent |=> !endOfWriteEvent;
  endproperty
  a_eow_pulse: assert property (p_eow_pulse)
    else $error("end of write longer than one cycle");

  property p_set_protection_select_clears;
    @(posedge clock) disable iff (!reset_n)
    (s_reg.state == FEWC_FLASH_RUN && s_next.state == FEWC_IDLE)
      |=> !s_reg.flashCtrl[FC_SET_PROTECTION_SELECT] && endOfWriteEvent;
  endproperty
  a_set_protection_select_clears: assert property (p_set_protection_select_clears)
    else $error("protection select not cleared at end");

  property p_busy_reads;
    @(posedge clock) disable iff (!reset_n)
    (busRead && flashSpace && !fcHit && !ecHit && flashAccessBlock)
      |=> busRdData == ERASED_BYTE;
  endproperty
  a_busy_reads: assert property (p_busy_reads)
    else $error("busy flash read not FFh");

  property p_resume;
    @(posedge clock) disable iff (!reset_n)
    (s_reg.state == FEWC_SUSPENDED && s_next.state == FEWC_FLASH_RUN)
      |=> s_reg.flashCtrl[FC_BUSY];
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not set flash busy");

  property p_no_sleep_in_write;
    @(posedge clock) disable iff (!reset_n)
    ($rose(s_reg.powerDown) || $rose(s_reg.lowPower))
      |-> !$past(writeActive);
  endproperty
  a_no_sleep_in_write: assert property (p_no_sleep_in_write)
    else $error("low power entered during a write");

  property p_irq_route;
    @(posedge clock) disable iff (!reset_n)
    $past(s_reg.eeCtrl[EC_IRQS]) |-> sharedIrq == $past(s_reg.endOfWrite);
  endproperty
  a_irq_route: assert property (p_irq_route)
    else $error("shared interrupt not routed from end of write");
endmodule // fewc_write_control

/* sim/flash_eeprom_write_control_tb_top.sv */
// Self-checking bench for the flash and EEPROM write controller.
// Assumes fewc_pkg is compiled first; drives every port at the falling edge.
`timescale 1ns/100ps
module flash_eeprom_write_control_tb_top;
  import fewc_pkg::*;

  // Short wake counts keep the run brief; expectations use the same value.
  localparam int unsigned WAKE  = 20;
  localparam int unsigned LIMIT = 5000;

  logic        clock;
  logic        reset_n;
  logic [23:0] busAddr;
  logic [7:0]  busWrData;
  logic        busWrite;
  logic        busRead;
  logic        flashSpace;
  logic        eeSpace;
  logic [7:0]  busRdData;
  logic        flashAccessBlock;
  logic        eeAccessBlock;
  logic        arrayDone;
  logic        sleepRequest;
  logic        arrayLowPower;
  logic        arrayPowerDown;
  logic        extIrqPin;
  logic        sharedIrq;
  logic        endOfWriteEvent;
  int          errors;
  int          cmp_count;
  int          cycles;
  int          seed;
  int          n;
  logic [7:0]  ecBase;
  logic [5:0]  page;

  fewc_write_control #(
    .FLASH_WAKE_CYCLES (WAKE),
    .EE_WAKE_CYCLES    (WAKE),
    .OP_CYCLES         (500)
  ) dut (
    .clock            (clock),
    .reset_n          (reset_n),
    .busAddr          (busAddr),
    .busWrData        (busWrData),
    .busWrite         (busWrite),
    .busRead          (busRead),
    .flashSpace       (flashSpace),
    .eeSpace          (eeSpace),
    .busRdData        (busRdData),
    .flashAccessBlock (flashAccessBlock),
    .eeAccessBlock    (eeAccessBlock),
    .arrayDone        (arrayDone),
    .sleepRequest     (sleepRequest),
    .arrayLowPower    (arrayLowPower),
    .arrayPowerDown   (arrayPowerDown),
    .extIrqPin        (extIrqPin),
    .sharedIrq        (sharedIrq),
    .endOfWriteEvent  (endOfWriteEvent)
  );

  initial clock = 1'b0;
  always #5 clock = ~clock;

  task automatic results();
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // A hang counts as a mismatch and ends in the common report.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      results();
    end
  end

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h got %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %b got %b", n, e, g);
    end
  endtask

  // The extra edge keeps two writes from touching busWrite in one step.
  task automatic wr(input logic [23:0] a, input logic [7:0] d,
                    input logic fs, input logic es);
    busAddr = a;
    busWrData = d;
    flashSpace = fs;
    eeSpace = es;
    busWrite = 1'b1;
    @(negedge clock);
    busWrite = 1'b0;
    flashSpace = 1'b0;
    eeSpace = 1'b0;
    @(negedge clock);
  endtask

  task automatic rd(input string n, input logic [23:0] a, input logic fs,
                    input logic es, input logic [7:0] e);
    busAddr = a;
    flashSpace = fs;
    eeSpace = es;
    busRead = 1'b1;
    @(negedge clock);
    busRead = 1'b0;
    flashSpace = 1'b0;
    eeSpace = 1'b0;
    chk8(n, e, busRdData);
    @(negedge clock);
  endtask

  task automatic done();
    arrayDone = 1'b1;
    @(negedge clock);
    arrayDone = 1'b0;
    chk1("endOfWriteEvent", 1'b1, endOfWriteEvent);
    @(negedge clock);
    chk1("endOfWriteEvent", 1'b0, endOfWriteEvent);
  endtask

  initial begin
    seed = 30131;
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    {busAddr, busWrData, busWrite, busRead, flashSpace, eeSpace} = '0;
    {arrayDone, sleepRequest, extIrqPin} = '0;
    reset_n = 1'b0;
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    chk1("flashBlock", 1'b1, flashAccessBlock);
    chk1("eeBlock", 1'b1, eeAccessBlock);
    rd("flash read waking", 24'h000100, 1'b1, 1'b0, ERASED_BYTE);
    repeat (WAKE + 4) @(negedge clock);
    chk1("flashBlock", 1'b0, flashAccessBlock);
    chk1("eeBlock", 1'b0, eeAccessBlock);
    rd("flash ctrl", FLASH_CTRL_ADDR, 1'b0, 1'b0, FLASH_CTRL_RST);
    rd("ee ctrl", EE_CTRL_ALIAS, 1'b0, 1'b0, EE_CTRL_RST);
    wr(EE_CTRL_ADDR, 8'h19, 1'b0, 1'b0);
    rd("ee ctrl", EE_CTRL_ALIAS, 1'b0, 1'b0, 8'h00);
    wr(FLASH_CTRL_ALIAS, 8'h01, 1'b0, 1'b0);
    rd("flash ctrl", FLASH_CTRL_ADDR, 1'b0, 1'b0, 8'h00);
    // Interrupt routing: pin first, then the end-of-write source.
    extIrqPin = 1'b1;
    repeat (4) @(negedge clock);
    chk1("sharedIrq pin", 1'b1, sharedIrq);
    ecBase = 8'h02;
    wr(EE_CTRL_ADDR, ecBase, 1'b0, 1'b0);
    repeat (3) @(negedge clock);
    chk1("sharedIrq eow", 1'b0, sharedIrq);
    // Set protection with all four bytes latched.
    wr(FLASH_CTRL_ADDR, 8'h02, 1'b0, 1'b0);
    rd("flash idle", 24'h001234, 1'b1, 1'b0, 8'h00);
    for (int i = 0; i < SET_PROTECTION_SELECT_BYTES; i++)
      wr(24'h000010 + 24'(i), 8'($random(seed)), 1'b1, 1'b0);
    chk1("flashBlock", 1'b1, flashAccessBlock);
    rd("flash ctrl", FLASH_CTRL_ADDR, 1'b0, 1'b0, 8'h03);
    rd("flash busy", 24'h001234, 1'b1, 1'b0, ERASED_BYTE);
    wr(FLASH_CTRL_ALIAS, 8'h82, 1'b0, 1'b0);
    rd("flash ctrl", FLASH_CTRL_ADDR, 1'b0, 1'b0, 8'h83);
    done();
    rd("flash ctrl", FLASH_CTRL_ADDR, 1'b0, 1'b0, 8'h00);
    rd("flash after", 24'h001234, 1'b1, 1'b0, 8'h00);
    // Chip erase: busy comes with the start bit, not the select.
    wr(FLASH_CTRL_ADDR, 8'h20, 1'b0, 1'b0);
    chk1("flashBlock", 1'b0, flashAccessBlock);
    wr(FLASH_CTRL_ADDR, 8'hA0, 1'b0, 1'b0);
    chk1("flashBlock", 1'b1, flashAccessBlock);
    done();
    rd("flash ctrl", FLASH_CTRL_ADDR, 1'b0, 1'b0, 8'h00);
    // Dropping the select after a latch cancels the pending program.
    wr(FLASH_CTRL_ADDR, 8'h40, 1'b0, 1'b0);
    wr(24'h000200, 8'h55, 1'b1, 1'b0);
    chk1("flashBlock", 1'b1, flashAccessBlock);
    wr(FLASH_CTRL_ADDR, 8'h00, 1'b0, 1'b0);
    chk1("flashBlock", 1'b0, flashAccessBlock);
    // Sector erase, suspend, blocked EEPROM update, resume.
    wr(FLASH_CTRL_ADDR, 8'h08, 1'b0, 1'b0);
    wr(24'h010000, 8'h00, 1'b1, 1'b0);
    wr(FLASH_CTRL_ADDR, 8'h88, 1'b0, 1'b0);
    wr(FLASH_CTRL_ADDR, 8'h8C, 1'b0, 1'b0);
    chk1("endOfWriteEvent", 1'b0, endOfWriteEvent);
    chk1("flashBlock", 1'b0, flashAccessBlock);
    rd("flash ctrl", FLASH_CTRL_ADDR, 1'b0, 1'b0, 8'h0C);
    rd("flash susp", 24'h001234, 1'b1, 1'b0, 8'h00);
    wr(EE_CTRL_ADDR, ecBase | 8'hC0, 1'b0, 1'b0);
    rd("ee ctrl", EE_CTRL_ADDR, 1'b0, 1'b0, ecBase);
    wr(FLASH_CTRL_ADDR, 8'h88, 1'b0, 1'b0);
    chk1("flashBlock", 1'b1, flashAccessBlock);
    rd("flash ctrl", FLASH_CTRL_ADDR, 1'b0, 1'b0, 8'h89);
    done();
    rd("flash ctrl", FLASH_CTRL_ADDR, 1'b0, 1'b0, 8'h00);
    // Page updates: one random count, then the full sixteen.
    for (int k = 0; k < 2; k++) begin
      n = (k == 0) ? 1 + ($random(seed) & 15) : PAGE_BYTES;
      page = 6'($random(seed));
      wr(EE_CTRL_ADDR, ecBase | 8'h40, 1'b0, 1'b0);
      for (int j = 0; j < n; j++)
        wr({14'h0880, page, 4'(j)}, 8'($random(seed)), 1'b0, 1'b1);
      chk1("eeBlock", 1'b1, eeAccessBlock);
      rd("ee busy", {14'h0880, page, 4'h0}, 1'b0, 1'b1, ERASED_BYTE);
      rd("flash free", 24'h001234, 1'b1, 1'b0, 8'h00);
      wr(EE_CTRL_ADDR, ecBase | 8'hC0, 1'b0, 1'b0);
      wr(EE_CTRL_ALIAS, ecBase | 8'h40, 1'b0, 1'b0);
      rd("ee ctrl", EE_CTRL_ADDR, 1'b0, 1'b0, ecBase | 8'hC1);
      done();
      chk1("sharedIrq eow", 1'b1, sharedIrq);
      rd("ee ctrl", EE_CTRL_ADDR, 1'b0, 1'b0, ecBase);
      chk1("eeBlock", 1'b0, eeAccessBlock);
    end
    // Chip erase with power-down requested meanwhile: entry is deferred.
    ecBase = 8'h06;
    extIrqPin = 1'b0;
    wr(EE_CTRL_ADDR, ecBase | 8'h20, 1'b0, 1'b0);
    wr(EE_CTRL_ADDR, ecBase | 8'hA0, 1'b0, 1'b0);
    chk1("eeBlock", 1'b1, eeAccessBlock);
    sleepRequest = 1'b1;
    repeat (6) @(negedge clock);
    chk1("arrayPowerDown", 1'b0, arrayPowerDown);
    done();
    repeat (4) @(negedge clock);
    chk1("arrayPowerDown", 1'b1, arrayPowerDown);
    rd("ee ctrl", EE_CTRL_ADDR, 1'b0, 1'b0, ecBase);
    sleepRequest = 1'b0;
    repeat (4) @(negedge clock);
    chk1("flashBlock", 1'b1, flashAccessBlock);
    chk1("eeBlock", 1'b1, eeAccessBlock);
    repeat (WAKE + 4) @(negedge clock);
    chk1("flashBlock", 1'b0, flashAccessBlock);
    chk1("eeBlock", 1'b0, eeAccessBlock);
    // Standby keeps the array readable at once.
    ecBase = 8'h02;
    wr(EE_CTRL_ADDR, ecBase, 1'b0, 1'b0);
    sleepRequest = 1'b1;
    repeat (5) @(negedge clock);
    chk1("arrayLowPower", 1'b1, arrayLowPower);
    chk1("arrayPowerDown", 1'b0, arrayPowerDown);
    chk1("flashBlock", 1'b0, flashAccessBlock);
    sleepRequest = 1'b0;
    repeat (4) @(negedge clock);
    // A reset in mid-write abandons it and reloads both wake timers.
    wr(EE_CTRL_ADDR, 8'hA0, 1'b0, 1'b0);
    reset_n = 1'b0;
    @(negedge clock);
    chk1("flashBlock", 1'b1, flashAccessBlock);
    reset_n = 1'b1;
    @(negedge clock);
    rd("ee ctrl", EE_CTRL_ADDR, 1'b0, 1'b0, 8'h01);
    results();
  end
endmodule // flash_eeprom_write_control_tb_top
